// File: core/sxl_ctrl.sv
// module: program exception control and low-power sequencing
`timescale 1ns/1ps
// Notes on behaviour
// - entry asks the cpu to stack registers and set mask; return restores
// - interrupt latched and arbitrated into vector; nothing but a reset pre-empts until serviced
// - pending requests checked at instruction end; need mask clear and enable
// - highest priority first; pending at return taken before next instruction
// - entry never stacks the high index byte register
// - software interrupt instruction traps regardless of the mask
// - software interrupt pushes pc, hardware interrupt pushes pc minus one
// - resets beat every interrupt and never take part in arbitration
// - break request forces the cpu to the software interrupt vector
// - in break, flags clearable only with clear enable; stay cleared
// - two-step clears stay blocked through break, work normally after
// - wait or stop clears the mask and stops cpu clocks
// - wait keeps peripheral clocks; enabled interrupt wakes, stack next cycle
// - wait also left by reset or break; break in wait sets flag
// - watchdog enabled and running in wait when disable bit is zero
// - stop resets counter, disables clocks; interrupt exit after recovery time
// - recovery is 4096 oscillator cycles, or 32 with short select
// - counter held reset in stop, times recovery; break idle in stop
// - break wait flag cleared by writing zero, and by reset
// - reading reset source status clears all of its flags
// - power-on reset sets its flag and clears all others
// - other resets set their own flag and leave others alone
// - illegal opcode, illegal fetch and low voltage flags also kept
module sxl_ctrl
    import sxl_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter int REC_LONG = SXL_REC_LONG,
    parameter int REC_SHORT = SXL_REC_SHORT
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // register port
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // cpu side
    input wire logic instr_done_i,       // current instruction completes
    input wire logic mask_i,             // interrupt mask from condition codes
    input wire logic trap_exec_i,        // software_interrupt_instr executed
    input wire logic wait_exec_i,
    input wire logic stop_exec_i,
    input wire logic service_ack_i,      // cpu finished stacking and vector fetch
    input wire logic brk_i,              // break module request
    input wire logic brk_exit_i,         // break state left
    // peripheral side
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic [NUM_IRQ-1:0] irq_en_i,
    input wire logic periph_clr_req_i,   // peripheral wants to clear a flag
    // reset causes, one-cycle pulses captured into status
    input wire logic por_i,
    input wire logic pin_rst_i,
    input wire logic wdog_rst_i,
    input wire logic ill_op_rst_i,
    input wire logic ill_addr_rst_i,
    input wire logic low_volt_rst_i,
    output sxl_cpu_ctl_t cpu_ctl_o,
    output logic in_break_o,
    output logic flag_clr_ok_o
);
    // -------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------
    typedef struct packed {
        sxl_state_t st;
        logic [12:0] cnt;
        logic [3:0] vec;
        logic is_trap;
        logic brk;
        logic [7:0] brk_stat;
        logic [7:0] rst_stat;
        logic [7:0] brk_ctrl;
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic [2:0] rst_sync;
        logic [2:0] rst_sync2;
        logic [NUM_IRQ-1:0] irq_s1;
        logic [NUM_IRQ-1:0] irq_s2;
        sxl_cpu_ctl_t ctl;
        logic clr_ok;
    } sxl_regs_t;

    sxl_regs_t cur_r;
    sxl_regs_t cur_nxt;

    // lowest index wins: fixed priority, resets never enter here
    function automatic logic [3:0] sxl_pick(input logic [NUM_IRQ-1:0] req);
        logic [3:0] idx;
        idx = 4'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 4'(i);
            end
        end
        return idx;
    endfunction

    logic [NUM_IRQ-1:0] live;
    logic [2:0] rst_pulse;
    logic [12:0] rec_len;

    // -------------------------------------------------------------------
    // next-state logic
    // -------------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        // watchdog and illegal opcode/address causes arrive from other logic; synchronise those pulses
        cur_nxt.rst_sync = {wdog_rst_i, ill_op_rst_i, ill_addr_rst_i};
        cur_nxt.rst_sync2 = cur_r.rst_sync;
        cur_nxt.irq_s1 = irq_i;
        cur_nxt.irq_s2 = cur_r.irq_s1;
        rst_pulse = cur_r.rst_sync2;
        live = cur_r.irq_s2 & irq_en_i;
        rec_len = cur_r.cfg[SXL_BIT_SHORT_REC] ? 13'(REC_SHORT) : 13'(REC_LONG);
        cur_nxt.ctl.stack_req = 1'b0;
        cur_nxt.ctl.set_mask = 1'b0;
        cur_nxt.ctl.clr_mask = 1'b0;
        cur_nxt.rdata = 8'h00;

        // register writes
        if (reg_wr_i) begin
            case (reg_addr_i)
                SXL_ADDR_BRK_STAT: begin
                    if (!reg_wdata_i[SXL_BIT_BRK_WAIT]) begin
                        cur_nxt.brk_stat[SXL_BIT_BRK_WAIT] = 1'b0;
                    end
                end
                SXL_ADDR_BRK_CTRL: cur_nxt.brk_ctrl = reg_wdata_i & 8'h80;
                SXL_ADDR_CONFIG: cur_nxt.cfg = reg_wdata_i & 8'h81;
                default: ;
            endcase
        end
        // register reads, data stands the next cycle
        if (reg_rd_i) begin
            case (reg_addr_i)
                SXL_ADDR_BRK_STAT: cur_nxt.rdata = cur_r.brk_stat;
                SXL_ADDR_RST_STAT: begin
                    cur_nxt.rdata = cur_r.rst_stat;
                    cur_nxt.rst_stat = 8'h00;
                end
                SXL_ADDR_BRK_CTRL: cur_nxt.rdata = cur_r.brk_ctrl;
                SXL_ADDR_CONFIG: cur_nxt.rdata = cur_r.cfg;
                default: cur_nxt.rdata = 8'h00;
            endcase
        end
        // non-power-on causes add their flag; set wins over read clear
        if (pin_rst_i) cur_nxt.rst_stat[SXL_RS_PIN] = 1'b1;
        if (rst_pulse[2]) cur_nxt.rst_stat[SXL_RS_WDOG] = 1'b1;
        if (rst_pulse[1]) cur_nxt.rst_stat[SXL_RS_ILL_OP] = 1'b1;
        if (rst_pulse[0]) cur_nxt.rst_stat[SXL_RS_ILL_ADDR] = 1'b1;
        if (low_volt_rst_i) cur_nxt.rst_stat[SXL_RS_LOW_VOLT] = 1'b1;

        // break tracking; break never stirs while stopped
        if (brk_i && cur_r.st != SXL_STOP) begin
            cur_nxt.brk = 1'b1;
        end else if (brk_exit_i) begin
            cur_nxt.brk = 1'b0;
        end

        // sequencer
        case (cur_r.st)
            SXL_RUN: begin
                cur_nxt.cnt = cur_r.cnt + 13'd1;
                if (instr_done_i) begin
                    if (brk_i) begin
                        cur_nxt.vec = SXL_TRAP_VEC;
                        cur_nxt.is_trap = 1'b1;
                        cur_nxt.st = SXL_STACK;
                    end else if (trap_exec_i) begin
                        cur_nxt.vec = SXL_TRAP_VEC;
                        cur_nxt.is_trap = 1'b1;
                        cur_nxt.st = SXL_STACK;
                    end else if (stop_exec_i) begin
                        cur_nxt.ctl.clr_mask = 1'b1;
                        cur_nxt.cnt = 13'd0;
                        cur_nxt.st = SXL_STOP;
                    end else if (wait_exec_i) begin
                        cur_nxt.ctl.clr_mask = 1'b1;
                        cur_nxt.st = SXL_WAIT;
                    end else if (!mask_i && |live) begin
                        cur_nxt.vec = sxl_pick(live);
                        cur_nxt.is_trap = 1'b0;
                        cur_nxt.st = SXL_STACK;
                    end
                end
            end
            SXL_STACK: begin
                // latched vector holds until the cpu acknowledges
                cur_nxt.ctl.stack_req = 1'b1;
                cur_nxt.ctl.set_mask = 1'b1;
                if (service_ack_i) begin
                    cur_nxt.ctl.stack_req = 1'b0;
                    cur_nxt.st = SXL_RUN;
                end
            end
            SXL_WAIT: begin
                cur_nxt.cnt = cur_r.cnt + 13'd1;
                if (brk_i) begin
                    cur_nxt.brk_stat[SXL_BIT_BRK_WAIT] = 1'b1;
                    cur_nxt.vec = SXL_TRAP_VEC;
                    cur_nxt.is_trap = 1'b1;
                    cur_nxt.st = SXL_STACK;
                end else if (|live) begin
                    cur_nxt.vec = sxl_pick(live);
                    cur_nxt.is_trap = 1'b0;
                    cur_nxt.st = SXL_STACK;
                end
            end
            SXL_STOP: begin
                cur_nxt.cnt = 13'd0;
                if (|live) begin
                    cur_nxt.vec = sxl_pick(live);
                    cur_nxt.is_trap = 1'b0;
                    cur_nxt.st = SXL_RECOV;
                end
            end
            SXL_RECOV: begin
                // counter times recovery before stacking
                cur_nxt.cnt = cur_r.cnt + 13'd1;
                if (cur_r.cnt >= rec_len - 13'd1) begin
                    cur_nxt.cnt = 13'd0;
                    cur_nxt.st = SXL_STACK;
                end
            end
            default: cur_nxt.st = SXL_RUN;
        endcase

        // clocks, watchdog and flag protection
        cur_nxt.ctl.vector = cur_nxt.vec;
        cur_nxt.ctl.push_pc_m1 = !cur_nxt.is_trap;
        cur_nxt.ctl.cpu_clk_en = !(cur_nxt.st inside {SXL_WAIT, SXL_STOP, SXL_RECOV});
        cur_nxt.ctl.periph_clk_en = !(cur_nxt.st inside {SXL_STOP, SXL_RECOV});
        cur_nxt.ctl.osc_en = (cur_nxt.st != SXL_STOP);
        cur_nxt.ctl.wdog_en = !cur_r.cfg[SXL_BIT_WDOG_DIS] && cur_nxt.ctl.periph_clk_en;
        cur_nxt.ctl.sys_cnt_rst = (cur_nxt.st == SXL_STOP);
        // a blocked first step stays blocked: peripherals gate both steps
        cur_nxt.clr_ok = !cur_nxt.brk || cur_r.brk_ctrl[SXL_BIT_CLR_EN];
        cur_nxt.ctl.flag_clr_en = cur_nxt.clr_ok && periph_clr_req_i;
    end

    // -------------------------------------------------------------------
    // registers; resets beat all interrupt activity
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_r <= '0;
            cur_r.st <= SXL_RUN;
            cur_r.brk_stat <= SXL_RST_BRK_STAT;
            cur_r.brk_ctrl <= SXL_RST_BRK_CTRL;
            cur_r.cfg <= SXL_RST_CONFIG;
            cur_r.ctl.cpu_clk_en <= 1'b1;
            cur_r.ctl.periph_clk_en <= 1'b1;
            cur_r.ctl.osc_en <= 1'b1;
            cur_r.clr_ok <= 1'b1;
        end else if (por_i) begin
            cur_r.rst_stat <= SXL_RST_RS_POR;
            cur_r.st <= SXL_RUN;
            cur_r.ctl.stack_req <= 1'b0;
            cur_r.brk_stat <= SXL_RST_BRK_STAT;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // high index byte is never part of the stack frame requested
    assign reg_rdata_o = cur_r.rdata;
    assign cpu_ctl_o = cur_r.ctl;
    assign in_break_o = cur_r.brk;
    assign flag_clr_ok_o = cur_r.clr_ok;
endmodule

// File: core/sxl_pkg.sv
// package: constants and carriers for the exception and low-power controller
package sxl_pkg;
    // -------------------------------------------------------------------
    // register map (word index on the plain register port)
    // -------------------------------------------------------------------
    localparam logic [3:0] SXL_ADDR_BRK_STAT = 4'h0;  // break_wait_status
    localparam logic [3:0] SXL_ADDR_RST_STAT = 4'h1;  // reset_source_status
    localparam logic [3:0] SXL_ADDR_BRK_CTRL = 4'h2;  // break_flag_control_reg
    localparam logic [3:0] SXL_ADDR_CONFIG = 4'h3;    // config_reg_one

    // field positions
    localparam int SXL_BIT_BRK_WAIT = 1;   // break_wait_flag in break_wait_status
    localparam int SXL_BIT_CLR_EN = 7;     // break_clear_enable
    localparam int SXL_BIT_SHORT_REC = 7;  // short_recovery_select in config
    localparam int SXL_BIT_WDOG_DIS = 0;   // watchdog_disable in config
    // reset_source_status bits
    localparam int SXL_RS_LOW_VOLT = 1;
    localparam int SXL_RS_ILL_ADDR = 3;
    localparam int SXL_RS_ILL_OP = 4;
    localparam int SXL_RS_WDOG = 5;
    localparam int SXL_RS_PIN = 6;
    localparam int SXL_RS_POR = 7;

    // reset values
    localparam logic [7:0] SXL_RST_BRK_STAT = 8'h00;
    localparam logic [7:0] SXL_RST_BRK_CTRL = 8'h00;
    localparam logic [7:0] SXL_RST_CONFIG = 8'h00;
    localparam logic [7:0] SXL_RST_RS_POR = 8'h80;

    // stop recovery counts in oscillator cycles
    localparam int SXL_REC_LONG = 4096;
    localparam int SXL_REC_SHORT = 32;
    localparam logic [3:0] SXL_TRAP_VEC = 4'hf;  // vector code of break/software trap

    // -------------------------------------------------------------------
    // types
    // -------------------------------------------------------------------
    typedef enum logic [4:0] {
        SXL_RUN = 5'b00001,
        SXL_STACK = 5'b00010,
        SXL_WAIT = 5'b00100,
        SXL_STOP = 5'b01000,
        SXL_RECOV = 5'b10000
    } sxl_state_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sxl_bus_req_t;

    typedef struct packed {
        logic stack_req;      // start stacking / vector fetch
        logic push_pc_m1;     // hardware entry pushes pc-1
        logic set_mask;       // set the mask at entry
        logic clr_mask;       // wait/stop clears the mask
        logic [3:0] vector;   // latched arbitration constant
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_en;
        logic wdog_en;
        logic flag_clr_en;    // peripherals may clear flags
        logic sys_cnt_rst;
    } sxl_cpu_ctl_t;
endpackage

// File: dv/sxl_ctrl_asserts.sv
// checker: port assertions of the exception and low-power controller
`timescale 1ns/1ps
module sxl_ctrl_asserts
    import sxl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic instr_done_i,
    input wire logic mask_i,
    input wire logic trap_exec_i,
    input wire logic wait_exec_i,
    input wire logic service_ack_i,
    input wire logic brk_i,
    input wire logic por_i,
    input wire sxl_cpu_ctl_t cpu_ctl_o
);
    // one clock domain; reset silences every check
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    entry_mask_a: assert property (
        $rose(cpu_ctl_o.stack_req) |-> cpu_ctl_o.set_mask) else $error("entry without mask");
    ack_drop_a: assert property (
        cpu_ctl_o.stack_req && service_ack_i |=> !cpu_ctl_o.stack_req)
        else $error("stack request outlives ack");
    latch_hold_a: assert property (
        cpu_ctl_o.stack_req && !service_ack_i && !por_i
        |=> cpu_ctl_o.stack_req && $stable(cpu_ctl_o.vector)) else $error("latched entry lost");
    hw_pc_a: assert property (
        $rose(cpu_ctl_o.stack_req) && cpu_ctl_o.vector != SXL_TRAP_VEC |-> cpu_ctl_o.push_pc_m1)
        else $error("hardware entry without pc minus one");
    trap_nomask_a: assert property (
        instr_done_i && trap_exec_i && mask_i && !brk_i && !por_i && !cpu_ctl_o.stack_req
        |-> ##[1:3] cpu_ctl_o.stack_req && !cpu_ctl_o.push_pc_m1) else $error("masked trap lost");
    por_first_a: assert property (
        por_i |-> ##2 !cpu_ctl_o.stack_req) else $error("entry survives power-on");
    brk_vec_a: assert property (
        instr_done_i && brk_i && !por_i && !cpu_ctl_o.stack_req
        |-> ##[1:3] cpu_ctl_o.stack_req && cpu_ctl_o.vector == SXL_TRAP_VEC)
        else $error("break not on trap vector");
    wait_entry_a: assert property (
        instr_done_i && wait_exec_i && !trap_exec_i && !brk_i && !por_i && !cpu_ctl_o.stack_req
        |=> cpu_ctl_o.clr_mask && !cpu_ctl_o.cpu_clk_en) else $error("wait entry wrong");
    stop_clk_a: assert property (
        !cpu_ctl_o.osc_en |-> !cpu_ctl_o.cpu_clk_en && !cpu_ctl_o.periph_clk_en
        && cpu_ctl_o.sys_cnt_rst) else $error("clocks or counter live in stop");
endmodule

bind sxl_ctrl sxl_ctrl_asserts chk (.*);

// File: dv/sxl_cpu_model.sv
// partner: cpu core that stacks, fetches the vector and keeps the mask
`timescale 1ns/1ps
module sxl_cpu_model
    import sxl_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire sxl_cpu_ctl_t cpu_ctl_i,
    input wire logic [3:0] ack_dly_i,
    input wire logic ret_i,
    output logic service_ack_o,
    output logic mask_o
);
    logic [3:0] cnt_r;
    // stacking lasts ack_dly_i+1 cycles; mask comes up set, as a core leaves reset
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= 4'h0;
            service_ack_o <= 1'b0;
            mask_o <= 1'b1;
        end else begin
            service_ack_o <= 1'b0;
            if (cpu_ctl_i.stack_req && !service_ack_o) begin
                service_ack_o <= (cnt_r == ack_dly_i);
                cnt_r <= (cnt_r == ack_dly_i) ? 4'h0 : cnt_r + 4'h1;
            end
            if (cpu_ctl_i.set_mask) begin
                mask_o <= 1'b1;
            end else if (cpu_ctl_i.clr_mask || ret_i) begin
                mask_o <= 1'b0;
            end
        end
    end
endmodule

// File: dv/tb_sys_exception_lowpower_ctrl.sv
// testbench: self-checking run of the exception and low-power controller
`timescale 1ns/1ps
module tb_sys_exception_lowpower_ctrl;
    import sxl_pkg::*;
    typedef struct packed {logic wr; logic [3:0] a; logic [7:0] d; logic [7:0] e;} sxl_row_t;
    logic clk, nrst, wr, rd, done, trp, wt, stp, brk, bex, clr, por, pin, wdg, iop, iad, lvr;
    logic ret, ack, mask, in_brk, clr_ok;
    logic [3:0] a, dly;
    logic [7:0] d, rdata, q, irq, en;
    sxl_cpu_ctl_t ctl;
    int failures, n_compared, n;
    // ----------------------------------------------------------------
    // register rows: write (optional), read back, expected value
    // ----------------------------------------------------------------
    sxl_row_t rows [8] = '{
        '{1'b0, SXL_ADDR_BRK_STAT, 8'h00, SXL_RST_BRK_STAT},
        '{1'b0, SXL_ADDR_BRK_CTRL, 8'h00, SXL_RST_BRK_CTRL},
        '{1'b0, SXL_ADDR_CONFIG, 8'h00, SXL_RST_CONFIG},
        '{1'b0, SXL_ADDR_RST_STAT, 8'h00, 8'h00},
        '{1'b1, SXL_ADDR_RST_STAT, 8'hff, 8'h00},
        '{1'b1, SXL_ADDR_BRK_CTRL, 8'h80, 8'h80},
        '{1'b1, SXL_ADDR_CONFIG, 8'h81, 8'h81},
        '{1'b1, 4'h9, 8'hff, 8'h00}};
    sxl_ctrl #(.REC_LONG(64), .REC_SHORT(8)) dut (.sys_clk_i(clk), .nrst_i(nrst),
        .reg_addr_i(a), .reg_wdata_i(d), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .instr_done_i(done), .mask_i(mask), .trap_exec_i(trp), .wait_exec_i(wt),
        .stop_exec_i(stp), .service_ack_i(ack), .brk_i(brk), .brk_exit_i(bex), .irq_i(irq),
        .irq_en_i(en), .periph_clr_req_i(clr), .por_i(por), .pin_rst_i(pin), .wdog_rst_i(wdg),
        .ill_op_rst_i(iop), .ill_addr_rst_i(iad), .low_volt_rst_i(lvr), .cpu_ctl_o(ctl),
        .in_break_o(in_brk), .flag_clr_ok_o(clr_ok));
    sxl_cpu_model cpu (.sys_clk_i(clk), .nrst_i(nrst), .cpu_ctl_i(ctl), .ack_dly_i(dly),
        .ret_i(ret), .service_ack_o(ack), .mask_o(mask));
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (e !== g) begin
            $display("wrong value %s expected %h seen %h", s, e, g);
            failures++;
        end
    endtask
    task automatic chkb(input string s, input logic e, input logic g);
        chk(s, {7'h0, e}, {7'h0, g});
    endtask
    task automatic wreg(input logic [3:0] ad, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        a <= ad;
        d <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [3:0] ad);
        @(posedge clk);
        rd <= 1'b1;
        a <= ad;
        @(posedge clk);
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    // one-cycle pulses: done lvr iad iop wdg pin por bex ret brk stp wt trp
    task automatic pulse(input logic [12:0] k);
        @(posedge clk);
        {done, lvr, iad, iop, wdg, pin, por, bex, ret, brk, stp, wt, trp} <= k;
        @(posedge clk);
        {done, lvr, iad, iop, wdg, pin, por, bex, ret, brk, stp, wt, trp} <= 13'h0000;
    endtask
    task automatic wstack(input int lim);
        n = 0;
        while (ctl.stack_req !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask
    // bounded wait for entry, check it, then let the model finish stacking
    task automatic take(input int lim, input logic [3:0] v, input logic pm);
        wstack(lim);
        chkb("stack request", 1'b1, ctl.stack_req);
        chk("vector", {4'h0, v}, {4'h0, ctl.vector});
        if (pm !== 1'bx) chkb("pc minus one", pm, ctl.push_pc_m1);
        // look after the edge has settled, never in the step that launches it
        for (int i = 0; i < 40 && ctl.stack_req === 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #20000;
        failures++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        {nrst, wr, rd, done, trp, wt, stp, brk, bex, clr, por, pin, wdg, iop, iad, lvr} = '0;
        {ret, a, d, irq, en} = '0;
        dly = 4'h2;
        failures = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) wreg(rows[i].a, rows[i].d);
            rreg(rows[i].a);
            chk("register", rows[i].e, q);
        end
        $display("register test done");
        // priority, mask, enable and latching of hardware entries
        pulse(13'h0010);
        en <= 8'hff;
        irq <= 8'h0a;
        repeat (3) @(posedge clk);
        pulse(13'h1000);
        take(8, 4'h1, 1'b1);
        dly <= 4'hc;
        pulse(13'h1000);
        wstack(6);
        chkb("no entry while masked", 1'b0, ctl.stack_req);
        pulse(13'h0010);
        pulse(13'h1000);
        wstack(8);
        irq <= 8'h09;
        repeat (4) @(posedge clk);
        take(4, 4'h1, 1'b1);
        dly <= 4'h1;
        pulse(13'h1001);
        take(8, SXL_TRAP_VEC, 1'b0);
        pulse(13'h0010);
        pulse(13'h1000);
        take(8, 4'h0, 1'b1);
        en <= 8'hf6;
        pulse(13'h0010);
        pulse(13'h1000);
        wstack(6);
        chkb("no entry when disabled", 1'b0, ctl.stack_req);
        irq <= 8'h00;
        $display("interrupt test done");
        // break entry and flag clear protection
        pulse(13'h1008);
        take(8, SXL_TRAP_VEC, 1'bx);
        chkb("in break", 1'b1, in_brk);
        chkb("clear allowed", 1'b1, clr_ok);
        wreg(SXL_ADDR_BRK_CTRL, 8'h00);
        clr <= 1'b1;
        @(posedge clk);
        #1 chkb("clear blocked", 1'b0, clr_ok);
        chkb("flag clear gated", 1'b0, ctl.flag_clr_en);
        pulse(13'h0030);
        @(posedge clk);
        #1 chkb("clear after break", 1'b1, clr_ok);
        chkb("flag clear passes", 1'b1, ctl.flag_clr_en);
        clr <= 1'b0;
        $display("break test done");
        // wait mode, left by break and by an interrupt
        wreg(SXL_ADDR_CONFIG, 8'h00);
        for (int i = 0; i < 2; i++) begin
            pulse(13'h1002);
            @(posedge clk);
            #1 chkb("cpu clock", 1'b0, ctl.cpu_clk_en);
            chkb("peripheral clock", 1'b1, ctl.periph_clk_en);
            chkb("watchdog", 1'b1, ctl.wdog_en);
            chkb("mask cleared", 1'b0, mask);
            if (i == 0) pulse(13'h0008);
            else irq <= 8'h04;
            take(12, i ? 4'h2 : SXL_TRAP_VEC, i ? 1'b1 : 1'bx);
            rreg(SXL_ADDR_BRK_STAT);
            chk("break wait", i ? 8'h00 : 8'h02, q);
            wreg(SXL_ADDR_BRK_STAT, 8'h00);
            irq <= 8'h00;
            pulse(13'h0030);
        end
        $display("wait test done");
        // stop mode with long then short recovery
        for (int i = 0; i < 2; i++) begin
            wreg(SXL_ADDR_CONFIG, i ? 8'h80 : 8'h00);
            pulse(13'h1004);
            @(posedge clk);
            #1 chkb("oscillator", 1'b0, ctl.osc_en);
            chkb("counter reset", 1'b1, ctl.sys_cnt_rst);
            irq <= 8'h04;
            wstack(120);
            chkb("recovery", 1'b1, n >= (i ? 8 : 64) && n <= (i ? 16 : 72));
            take(4, 4'h2, 1'b1);
            irq <= 8'h00;
            pulse(13'h0010);
        end
        $display("stop test done");
        // reset source flags
        pulse(13'h0040);
        rreg(SXL_ADDR_RST_STAT);
        chk("power-on flags", SXL_RST_RS_POR, q);
        pulse(13'h0f80);
        repeat (4) @(posedge clk);
        rreg(SXL_ADDR_RST_STAT);
        chk("source flags", 8'h7a, q);
        rreg(SXL_ADDR_RST_STAT);
        chk("flags after read", 8'h00, q);
        pulse(13'h0080);
        pulse(13'h0040);
        rreg(SXL_ADDR_RST_STAT);
        chk("power-on clears", SXL_RST_RS_POR, q);
        // mid-run reset: short recovery select was left set by the stop test
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rreg(SXL_ADDR_CONFIG);
        chk("config after reset", SXL_RST_CONFIG, q);
        $display("reset status test done");
        end_of_test();
    end
endmodule
